//--- rtl/trigger_control_top.sv
// Functional notes
// [R1] Result: top eight bits in upper byte, low two in bits 7:6, rest zero.
// [R2] Each conversion lands in the result register of its own input; in scan mode the code writes the register of the next input in the scan.
// [R3] Upper byte read directly; lower byte comes from the holding register.
// [R4] Results clear on reset or standby, untouched by manual reset.
// [R5] Control/status clears on reset or standby, untouched by manual reset.
// [R6] End flag sets after single conversion, or after whole scan group.
// [R7] Software clears end flag only by writing zero after reading it as one.
// [R8] Transfer engine access triggered by completion clears the end flag.
// [R9] Completion interrupt raised only while interrupt enable bit is one.
// [R10] Single mode start bit holds during conversion, self-clears at end.
// [R11] Scan mode converts selected inputs repeatedly until start bit cleared.
// [R12] Start bit zero halts conversion at once.
// [R13] An enabled trigger sets the start bit like a software write.
// [R14] Mode bit selects single or scan; change only while stopped.
// [R15] Speed bit picks long (266) or short (134) conversion time.
// [R16] Software keeps speed bit zero above 20 MHz, changes it when stopped.
// [R17] Reserved control/status bit 2 reads zero; software writes zero.
// [R18] Channel bits pick one input, or first one to four inputs in scan.
// [R19] Software changes channel bits only while stopped.
// [R20] Trigger control resets to 0x7f on reset or standby only.
// [R21] Trigger enable admits external pin falling edge or timer trigger.
// [R22] Both units share trigger sources; their enables are ORed.
// [R23] Trigger control bits 6:0 read one; software writes ones.
// [R24] Upper byte read latches lower byte into holding register first.
// [R25] Whole result register updates at once at end of conversion.
module trigger_control_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_standby,
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_ext_trig_n,
  input wire logic i_timer_trig,
  input wire logic [1:0] i_xfer_access,
  input wire logic [9:0] i_sample_data0,
  input wire logic [9:0] i_sample_data1,
  output logic [7:0] o_rdata,
  output logic [1:0] o_completion_irq,
  output logic [1:0] o_chan0,
  output logic [1:0] o_chan1
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [9:0] result_reg [0:7];
  logic [1:0] end_flag_reg;
  logic [1:0] flag_armed_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] start_reg;
  logic [1:0] scan_reg;
  logic [1:0] fast_reg;
  logic [1:0] ch_hi_reg;
  logic [1:0] ch_lo_reg;
  logic [1:0] trig_en_reg;
  logic [1:0] temp_reg;
  logic [7:0] rdata_next;
  logic trig_pulse;
  logic [1:0] conv_done;
  logic [1:0] group_end;
  logic [1:0] single_end;
  logic [1:0] chan [0:1];
  logic [9:0] sample [0:1];
  logic [7:0] csr_view [0:1];
  logic [7:0] trig_view [0:1];

  assign sample[0] = i_sample_data0;
  assign sample[1] = i_sample_data1;
  assign o_chan0 = chan[0];
  assign o_chan1 = chan[1];

  // ----------------------------------------------------------------
  // Shared trigger
  // ----------------------------------------------------------------
  // One detector for both units keeps their starts in the same cycle
  trigger_control_trig u_trig (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_standby(i_standby),
    .i_ext_trig_n(i_ext_trig_n),
    .i_timer_trig(i_timer_trig),
    .i_trig_en(trig_en_reg),
    .o_trig(trig_pulse)
  );

  // ----------------------------------------------------------------
  // Per-unit control
  // ----------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < trigger_control_pkg::NUM_UNITS; u++) begin : g_unit
      logic csr_sel;
      logic csr_wr;
      logic csr_rd;
      logic trig_wr;

      assign csr_sel = (i_addr == (trigger_control_pkg::CSR0_OFFSET + 5'(u)));
      assign csr_wr = i_wr && csr_sel;
      assign csr_rd = i_rd && csr_sel;
      assign trig_wr = i_wr && (i_addr == (trigger_control_pkg::TRIG0_OFFSET + 5'(u)));

      trigger_control_seq #(
        .CHANNELS(trigger_control_pkg::CH_PER_UNIT)
      ) u_seq (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_standby(i_standby),
        .i_start(start_reg[u]),
        .i_scan(scan_reg[u]),
        .i_fast(fast_reg[u]),
        .i_ch_sel({ch_hi_reg[u], ch_lo_reg[u]}),
        .o_chan(chan[u]),
        .o_done(conv_done[u]),
        .o_group_end(group_end[u]),
        .o_single_end(single_end[u])
      );

      // ----------------------------------------------------------------
      // Mode, speed, channel and enable bits
      // ----------------------------------------------------------------
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          irq_en_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::IRQ_EN_BIT];
          scan_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::SCAN_BIT];
          fast_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::SPEED_BIT];
          ch_hi_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::CH_HI_BIT];
          ch_lo_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::CH_LO_BIT];
        end else if (i_ce) begin
          if (i_standby) begin
            irq_en_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::IRQ_EN_BIT];  // see [R5]
            scan_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::SCAN_BIT];
            fast_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::SPEED_BIT];
            ch_hi_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::CH_HI_BIT];
            ch_lo_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::CH_LO_BIT];
          end else if (csr_wr) begin
            irq_en_reg[u] <= i_wdata[trigger_control_pkg::IRQ_EN_BIT];
            scan_reg[u] <= i_wdata[trigger_control_pkg::SCAN_BIT];  // see [R14]
            fast_reg[u] <= i_wdata[trigger_control_pkg::SPEED_BIT];  // see [R15]
            ch_hi_reg[u] <= i_wdata[trigger_control_pkg::CH_HI_BIT];  // see [R18]
            ch_lo_reg[u] <= i_wdata[trigger_control_pkg::CH_LO_BIT];
          end
        end
      end

      // ----------------------------------------------------------------
      // Start bit: trigger set beats software, which beats self-clear
      // ----------------------------------------------------------------
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          start_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::START_BIT];
        end else if (i_ce) begin
          if (i_standby) begin
            start_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::START_BIT];  // see [R5]
          end else if (trig_pulse) begin
            start_reg[u] <= 1'b1;  // see [R13]
          end else if (csr_wr) begin
            start_reg[u] <= i_wdata[trigger_control_pkg::START_BIT];  // see [R12]
          end else if (single_end[u]) begin
            start_reg[u] <= 1'b0;  // see [R10]
          end
        end
      end

      // ----------------------------------------------------------------
      // End flag: a completion in the clearing cycle wins
      // ----------------------------------------------------------------
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          end_flag_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::END_FLAG_BIT];
          flag_armed_reg[u] <= 1'b0;
        end else if (i_ce) begin
          if (i_standby) begin
            end_flag_reg[u] <= trigger_control_pkg::CSR_RESET[trigger_control_pkg::END_FLAG_BIT];
            flag_armed_reg[u] <= 1'b0;
          end else if (group_end[u]) begin
            end_flag_reg[u] <= 1'b1;  // see [R6]
          end else if (i_xfer_access[u]) begin
            end_flag_reg[u] <= 1'b0;  // see [R8]
            flag_armed_reg[u] <= 1'b0;
          end else if (csr_wr) begin
            if (flag_armed_reg[u] && !i_wdata[trigger_control_pkg::END_FLAG_BIT]) begin
              end_flag_reg[u] <= 1'b0;  // see [R7]
            end
            flag_armed_reg[u] <= 1'b0;
          end else if (csr_rd && end_flag_reg[u]) begin
            flag_armed_reg[u] <= 1'b1;  // see [R7]
          end
        end
      end

      // ----------------------------------------------------------------
      // Trigger enable bit
      // ----------------------------------------------------------------
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          trig_en_reg[u] <= trigger_control_pkg::TRIG_RESET[trigger_control_pkg::TRIG_EN_BIT];
        end else if (i_ce) begin
          if (i_standby) begin
            trig_en_reg[u] <= trigger_control_pkg::TRIG_RESET[trigger_control_pkg::TRIG_EN_BIT];  // see [R20]
          end else if (trig_wr) begin
            trig_en_reg[u] <= i_wdata[trigger_control_pkg::TRIG_EN_BIT];  // see [R21]
          end
        end
      end

      // ----------------------------------------------------------------
      // Interrupt request follows flag only while enabled
      // ----------------------------------------------------------------
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_completion_irq[u] <= 1'b0;
        end else if (i_ce) begin
          o_completion_irq[u] <= end_flag_reg[u] && irq_en_reg[u] && !i_standby;  // see [R9]
        end
      end

      // ----------------------------------------------------------------
      // Register views for the read mux
      // ----------------------------------------------------------------
      assign csr_view[u] = {end_flag_reg[u], irq_en_reg[u], start_reg[u], scan_reg[u], fast_reg[u],
                            1'b0, ch_hi_reg[u], ch_lo_reg[u]};  // see [R17]
      assign trig_view[u] = {trig_en_reg[u], trigger_control_pkg::TRIG_RSVD_ONES};  // see [R23]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result store; whole word written in one edge so reads never tear
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < trigger_control_pkg::NUM_UNITS * trigger_control_pkg::CH_PER_UNIT; r++) begin : g_result
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          result_reg[r] <= trigger_control_pkg::RESULT_RESET;
        end else if (i_ce) begin
          if (i_standby) begin
            result_reg[r] <= trigger_control_pkg::RESULT_RESET;  // see [R4]
          end else if (conv_done[r / 4] && chan[r / 4] == 2'(r % 4)) begin
            result_reg[r] <= sample[r / 4];  // see [R2] [R25]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Holding register for the low result byte
  // ----------------------------------------------------------------
  // One register serves all eight results, so interleaved pair reads clobber it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_reg <= 2'b00;
    end else if (i_ce) begin
      if (i_standby) begin
        temp_reg <= 2'b00;
      end else if (i_rd && i_addr <= trigger_control_pkg::RESULT_LAST && !i_addr[0]) begin
        temp_reg <= result_reg[i_addr[3:1]][trigger_control_pkg::RESULT_LOW_BITS-1:0];  // see [R24]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (i_addr <= trigger_control_pkg::RESULT_LAST) begin
      if (!i_addr[0]) begin
        rdata_next = result_reg[i_addr[3:1]][9:2];  // see [R1] [R3]
      end else begin
        rdata_next = {temp_reg, trigger_control_pkg::RESULT_PAD};  // see [R1] [R3]
      end
    end else if (i_addr == trigger_control_pkg::CSR0_OFFSET || i_addr == trigger_control_pkg::CSR1_OFFSET) begin
      rdata_next = csr_view[i_addr[0]];
    end else if (i_addr == trigger_control_pkg::TRIG0_OFFSET || i_addr == trigger_control_pkg::TRIG1_OFFSET) begin
      rdata_next = trig_view[i_addr[0]];
    end
  end

  // ----------------------------------------------------------------
  // Read byte, held between reads so a slow CPU sees a stable value
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      // Standby clears it too, so no stale result outlives power-down
      if (i_standby) begin
        o_rdata <= 8'h00;
      end else if (i_rd) begin
        o_rdata <= rdata_next;
      end
    end
  end

endmodule

//--- rtl/trigger_control_pkg.sv
package trigger_control_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets within the converter block)
  // ----------------------------------------------------------------
  localparam logic [4:0] RESULT_BASE = 5'h00;
  localparam logic [4:0] RESULT_LAST = 5'h0f;
  localparam logic [4:0] CSR0_OFFSET = 5'h10;
  localparam logic [4:0] CSR1_OFFSET = 5'h11;
  localparam logic [4:0] TRIG0_OFFSET = 5'h12;
  localparam logic [4:0] TRIG1_OFFSET = 5'h13;

  // ----------------------------------------------------------------
  // Control/status fields
  // ----------------------------------------------------------------
  localparam int END_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int START_BIT = 5;
  localparam int SCAN_BIT = 4;
  localparam int SPEED_BIT = 3;
  localparam int RSVD_CSR_BIT = 2;
  localparam int CH_HI_BIT = 1;
  localparam int CH_LO_BIT = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Trigger control fields
  // ----------------------------------------------------------------
  localparam int TRIG_EN_BIT = 7;
  localparam logic [6:0] TRIG_RSVD_ONES = 7'h7f;
  localparam logic [7:0] TRIG_RESET = 8'h7f;

  // ----------------------------------------------------------------
  // Result layout
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 10;
  localparam int RESULT_LOW_BITS = 2;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [5:0] RESULT_PAD = 6'h00;

  // ----------------------------------------------------------------
  // Conversion timing in states (one state is one clock)
  // ----------------------------------------------------------------
  localparam logic [8:0] FIRST_SLOW_STATES = 9'd266;
  localparam logic [8:0] FIRST_FAST_STATES = 9'd134;
  localparam logic [8:0] NEXT_SLOW_STATES = 9'd256;
  localparam logic [8:0] NEXT_FAST_STATES = 9'd128;

  localparam int NUM_UNITS = 2;
  localparam int CH_PER_UNIT = 4;

endpackage

//--- rtl/trigger_control_trig.sv
module trigger_control_trig (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_standby,
  input wire logic i_ext_trig_n,
  input wire logic i_timer_trig,
  input wire logic [1:0] i_trig_en,
  output logic o_trig
);

  logic ext_prev_reg;
  logic any_en;

  assign any_en = |i_trig_en;  // see [R22]

  // ----------------------------------------------------------------
  // Edge detect: the active-low pin fires on its falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_prev_reg <= 1'b1;
    end else if (i_ce) begin
      ext_prev_reg <= i_standby ? 1'b1 : i_ext_trig_n;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trig <= 1'b0;
    end else if (i_ce) begin
      o_trig <= any_en && !i_standby && ((ext_prev_reg && !i_ext_trig_n) || i_timer_trig);  // see [R21]
    end
  end

endmodule

//--- rtl/trigger_control_seq.sv
module trigger_control_seq #(
  parameter int CHANNELS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_standby,
  input wire logic i_start,
  input wire logic i_scan,
  input wire logic i_fast,
  input wire logic [1:0] i_ch_sel,
  output logic [1:0] o_chan,
  output logic o_done,
  output logic o_group_end,
  output logic o_single_end
);

  typedef enum logic [1:0] {
    TRIGGER_CONTROL_IDLE = 2'b01,
    TRIGGER_CONTROL_CONV = 2'b10
  } trigger_control_seq_e;

  trigger_control_seq_e state_reg;
  logic [8:0] count_reg;
  logic [1:0] last_chan;
  logic count_end;

  // Scan covers inputs 0..code; single converts only the coded input
  assign last_chan = i_scan ? i_ch_sel : o_chan;  // see [R18]
  assign count_end = (count_reg == 9'd1);

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= TRIGGER_CONTROL_IDLE;
      count_reg <= 9'd0;
      o_chan <= 2'd0;
      o_done <= 1'b0;
      o_group_end <= 1'b0;
      o_single_end <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      o_group_end <= 1'b0;
      o_single_end <= 1'b0;
      if (i_standby || !i_start) begin
        state_reg <= TRIGGER_CONTROL_IDLE;  // see [R12]
        count_reg <= 9'd0;
      end else begin
        case (state_reg)
          TRIGGER_CONTROL_IDLE: begin
            state_reg <= TRIGGER_CONTROL_CONV;
            o_chan <= i_scan ? 2'd0 : i_ch_sel;  // see [R18]
            count_reg <= i_fast ? trigger_control_pkg::FIRST_FAST_STATES : trigger_control_pkg::FIRST_SLOW_STATES;  // see [R15]
          end
          TRIGGER_CONTROL_CONV: begin
            if (count_end) begin
              o_done <= 1'b1;  // see [R2]
              if (!i_scan) begin
                o_group_end <= 1'b1;  // see [R6]
                o_single_end <= 1'b1;  // see [R10]
                state_reg <= TRIGGER_CONTROL_IDLE;
                count_reg <= 9'd0;
              end else begin
                // Later passes skip the start delay, so the count is shorter (256 or 128)
                count_reg <= i_fast ? trigger_control_pkg::NEXT_FAST_STATES : trigger_control_pkg::NEXT_SLOW_STATES;
                if (o_chan == last_chan || o_chan == 2'(CHANNELS - 1)) begin
                  o_group_end <= 1'b1;  // see [R6]
                  o_chan <= 2'd0;  // see [R11]
                end else begin
                  o_chan <= o_chan + 2'd1;
                end
              end
            end else begin
              count_reg <= count_reg - 9'd1;
            end
          end
          default: begin
            state_reg <= TRIGGER_CONTROL_IDLE;
          end
        endcase
      end
    end
  end

endmodule

//--- sim/trigger_control_top_asserts.sv
// ----------------------------------------------------------------
// Port checker for the converter register block
// ----------------------------------------------------------------
module trigger_control_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_standby,
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_completion_irq,
  input wire logic [1:0] o_chan0
);
  wire logic rd_ok = i_ce & i_rd;
  wire logic csr0_wr = i_ce & i_wr & (i_addr == trigger_control_pkg::CSR0_OFFSET);
  wire logic [1:0] wch = i_wdata[1:0];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_low_pad;
    rd_ok && i_addr <= trigger_control_pkg::RESULT_LAST && i_addr[0] |=> o_rdata[5:0] == 6'h00;
  endproperty
  a_low_pad: assert property (p_low_pad) else $error("low result byte padding not zero");

  property p_csr_rsvd;
    rd_ok && (i_addr == trigger_control_pkg::CSR0_OFFSET || i_addr == trigger_control_pkg::CSR1_OFFSET) |=> !o_rdata[2];
  endproperty
  a_csr_rsvd: assert property (p_csr_rsvd) else $error("reserved control bit read as one");

  property p_trig_ones;
    rd_ok && (i_addr == trigger_control_pkg::TRIG0_OFFSET || i_addr == trigger_control_pkg::TRIG1_OFFSET) |=> o_rdata[6:0] == 7'h7f;
  endproperty
  a_trig_ones: assert property (p_trig_ones) else $error("trigger reserved bits not all one");

  property p_unmapped;
    rd_ok && i_addr > trigger_control_pkg::TRIG1_OFFSET |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read not zero");

  // Read data must not drift between reads, or a split result read tears
  property p_hold;
    i_ce && !i_rd && !i_standby |=> $stable(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");

  property p_standby;
    i_ce && i_standby |=> o_completion_irq == 2'h0 && o_rdata == 8'h00;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not clear state");

  property p_irq_off;
    csr0_wr && !i_wdata[6] |=> ##1 !o_completion_irq[0];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq stayed up with enable cleared");

  property p_chan;
    csr0_wr && i_wdata[5] && !i_wdata[4] |-> ##3 o_chan0 == $past(wch, 3);
  endproperty
  a_chan: assert property (p_chan) else $error("single mode converts wrong input");
endmodule

bind trigger_control_top trigger_control_top_asserts u_asserts (.i_clk, .i_rst_n, .i_ce, .i_standby, .i_addr, .i_rd, .i_wr,
  .i_wdata, .o_rdata, .o_completion_irq, .o_chan0);

//--- sim/trigger_control_core_model.sv
// ----------------------------------------------------------------
// Analog core stand-in
// ----------------------------------------------------------------
module trigger_control_core_model (
  input wire logic [1:0] i_chan0,
  input wire logic [1:0] i_chan1,
  output logic [9:0] o_data0,
  output logic [9:0] o_data1
);
  // Level differs per unit and input so a misrouted result shows up
  assign o_data0 = {i_chan0, 6'h2d, i_chan0};
  assign o_data1 = {i_chan1, 6'h13, ~i_chan1};
endmodule

//--- sim/tb.sv
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w;
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } trigger_control_row_s;
  logic i_clk, i_rst_n, i_ce, i_standby, i_rd, i_wr, i_ext_trig_n, i_timer_trig;
  logic [4:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [1:0] i_xfer_access, o_completion_irq, o_chan0, o_chan1;
  logic [9:0] i_sample_data0, i_sample_data1, s;
  int n_mismatch, check_count, n;
  trigger_control_row_s rows [12];

  trigger_control_top DUT (.i_clk, .i_rst_n, .i_ce, .i_standby, .i_addr, .i_rd, .i_wr, .i_wdata, .i_ext_trig_n,
    .i_timer_trig, .i_xfer_access, .i_sample_data0, .i_sample_data1, .o_rdata, .o_completion_irq,
    .o_chan0, .o_chan1);
  trigger_control_core_model u_core (.i_chan0(o_chan0), .i_chan1(o_chan1), .o_data0(i_sample_data0),
    .o_data1(i_sample_data1));

  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [9:0] smp(input int u, input logic [1:0] c);
    return u ? {c, 6'h13, ~c} : {c, 6'h2d, c};
  endfunction

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = v;
    i_wr = 1'h1;
    @(negedge i_clk);
    i_wr = 1'h0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'h1;
    @(negedge i_clk);
    i_rd = 1'h0;
    chk($sformatf("offset %h", a), o_rdata, e);
  endtask

  // Bounded wait so a missing completion cannot hang the run
  task automatic wirq(input int u);
    n = 0;
    while (o_completion_irq[u] !== 1'h1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic tchk(input int t);
    chk("irq delay", {7'h00, n >= t && n <= t + 6}, 8'h01);
  endtask

  task automatic timer_pulse;
    @(negedge i_clk);
    i_timer_trig = 1'h1;
    @(negedge i_clk);
    i_timer_trig = 1'h0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    rows = '{'{1'h0, 5'h10, 8'h00, 8'h00}, '{1'h0, 5'h11, 8'h00, 8'h00}, '{1'h0, 5'h12, 8'h00, 8'h7f},
      '{1'h0, 5'h13, 8'h00, 8'h7f}, '{1'h0, 5'h1f, 8'h00, 8'h00}, '{1'h0, 5'h07, 8'h00, 8'h00},
      '{1'h1, 5'h10, 8'h80, 8'h00}, '{1'h1, 5'h10, 8'h0b, 8'h0b}, '{1'h1, 5'h12, 8'h7f, 8'h7f},
      '{1'h1, 5'h13, 8'hff, 8'hff}, '{1'h1, 5'h06, 8'hff, 8'h00}, '{1'h1, 5'h14, 8'hff, 8'h00}};
    i_rst_n = 1'h0;
    i_ce = 1'h1;
    i_standby = 1'h0;
    i_rd = 1'h0;
    i_wr = 1'h0;
    i_addr = 5'h00;
    i_wdata = 8'h00;
    i_ext_trig_n = 1'h1;
    i_timer_trig = 1'h0;
    i_xfer_access = 2'h0;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'h1;
    foreach (rows[k]) begin
      if (rows[k].w) begin
        wr(rows[k].a, rows[k].d);
      end
      rchk(rows[k].a, rows[k].e);
    end
    for (int u = 0; u < 2; u++) begin
      for (int c = 0; c < 4; c++) begin
        d = {4'h6, c[0], 1'h0, c[1:0]};
        wr(5'(16 + u), d);
        wirq(u);
        tchk(c[0] ? 134 : 266);
        rchk(5'(16 + u), (d & 8'hdf) | 8'h80);
        wr(5'(16 + u), 8'hc0);
        wr(5'(16 + u), 8'h40);
        chk("irq held", {7'h00, o_completion_irq[u]}, 8'h01);
        rchk(5'(16 + u), 8'hc0);
        wr(5'(16 + u), 8'h40);
        @(negedge i_clk);
        chk("irq cleared", {7'h00, o_completion_irq[u]}, 8'h00);
        s = smp(u, c[1:0]);
        rchk(5'(8 * u + 2 * c), s[9:2]);
        rchk(5'(8 * u + 2 * c + 1), {s[1:0], 6'h00});
      end
    end
    wr(5'h10, 8'h71);
    wirq(0);
    tchk(522);
    rchk(5'h10, 8'hf1);
    // Stop first; mode and channel change only once stopped
    wr(5'h10, 8'h11);
    repeat (600) @(negedge i_clk);
    rchk(5'h10, 8'h11);
    wr(5'h10, 8'h60);
    repeat (100) @(negedge i_clk);
    wr(5'h10, 8'h40);
    repeat (400) @(negedge i_clk);
    chk("stopped", {6'h00, o_completion_irq}, 8'h00);
    wr(5'h13, 8'hff);
    wr(5'h11, 8'h42);
    @(negedge i_clk);
    i_ext_trig_n = 1'h0;
    repeat (4) @(negedge i_clk);
    i_ext_trig_n = 1'h1;
    wirq(0);
    @(negedge i_clk);
    chk("both irq", {6'h00, o_completion_irq}, 8'h03);
    s = smp(1, 2'h2);
    rchk(5'h0c, s[9:2]);
    rchk(5'h11, 8'hc2);
    wr(5'h11, 8'h42);
    rchk(5'h10, 8'hc0);
    wr(5'h10, 8'h40);
    wr(5'h13, 8'h7f);
    timer_pulse();
    repeat (400) @(negedge i_clk);
    chk("trigger ignored", {6'h00, o_completion_irq}, 8'h00);
    wr(5'h12, 8'hff);
    timer_pulse();
    wirq(0);
    chk("timer start", {7'h00, o_completion_irq[0]}, 8'h01);
    @(negedge i_clk);
    i_xfer_access = 2'h3;
    @(negedge i_clk);
    i_xfer_access = 2'h0;
    @(negedge i_clk);
    chk("xfer clear", {6'h00, o_completion_irq}, 8'h00);
    @(negedge i_clk);
    i_standby = 1'h1;
    @(negedge i_clk);
    i_standby = 1'h0;
    rchk(5'h12, 8'h7f);
    rchk(5'h0c, 8'h00);
    rchk(5'h10, 8'h00);
    wr(5'h13, 8'hff);
    wr(5'h11, 8'h43);
    @(negedge i_clk);
    i_rst_n = 1'h0;
    @(negedge i_clk);
    i_rst_n = 1'h1;
    rchk(5'h13, 8'h7f);
    rchk(5'h11, 8'h00);
    complete_run();
  end
endmodule
